// ===== design/uar_defines.vh
// register offsets, field positions, reset values and rate divisors
// for the serial address recognition block; definitions only
`ifndef UAR_DEFINES_VH
`define UAR_DEFINES_VH

// register offsets on the register port
`define UAR_OFS_SERIAL_CONTROL    8'h98
`define UAR_OFS_SLAVE_ADDRESS     8'hA9
`define UAR_OFS_SLAVE_ADDR_MASK   8'hB9
`define UAR_OFS_POWER_CONTROL     8'h87
`define UAR_OFS_CLOCK_CONTROL     8'h8F

// serial_control fields
`define UAR_SC_FE_OR_MODE0        7
`define UAR_SC_MODE1              6
`define UAR_SC_MP_ENABLE          5
`define UAR_SC_RX_ENABLE          4
`define UAR_SC_TX_BIT9            3
`define UAR_SC_RX_BIT9            2
`define UAR_SC_TX_FLAG            1
`define UAR_SC_RX_FLAG            0

// power_control fields
`define UAR_PC_BAUD_DOUBLE        7
`define UAR_PC_FE_SELECT          6
`define UAR_PC_USED_MASK          8'hC0

// clock_control fields
`define UAR_CC_DOUBLE_SPEED       0
`define UAR_CC_USED_MASK          8'h01

// reset values
`define UAR_RST_SERIAL_CONTROL    8'h00
`define UAR_RST_SLAVE_ADDRESS     8'h00
`define UAR_RST_SLAVE_ADDR_MASK   8'h00
`define UAR_RST_POWER_CONTROL     8'h00
`define UAR_RST_CLOCK_CONTROL     8'h00

// serial modes
`define UAR_MODE_SHIFT            2'h0
`define UAR_MODE_UART8            2'h1
`define UAR_MODE_UART9_FIXED      2'h2
`define UAR_MODE_UART9_VAR        2'h3

// fixed rate divisors of the crystal clock
`define UAR_DIV_MODE0             7'h0C
`define UAR_DIV_MODE0_X2          7'h06
`define UAR_DIV_MODE2             7'h40
`define UAR_DIV_MODE2_DBL         7'h20
`define UAR_DIV_MODE2_X2          7'h20
`define UAR_DIV_MODE2_DBL_X2      7'h10
`define UAR_DIV_NONE              7'h00

`endif

// ===== design/uar_addr_recog.v
// serial control, slave address and mask registers with address recognition
// assumes a receive shifter that pulses rx_done_in once per frame with the
// byte, the ninth (or stop) bit and a stop-valid flag, all synchronous
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uar_defines.vh"

// Notes on behaviour
// - given address: mask zeros are don't-care
// - all-ones mask means exact address match
// - broadcast is address OR mask, zeros don't-care
// - address and mask reset to zero
// - framing error sticky until software clears
// - bit 7 is error flag or mode bit
// - two mode bits pick four modes
// - fixed rate in modes 0, 2; variable otherwise
// - multiprocessor enable acts in modes 1-3 only
// - own frame matches given or broadcast address
// - multiprocessor mode flags only own addresses
// - mode 1 with multiprocessor enable needs match plus valid stop
// - framing check needs select bit, modes 1-3
module uar_addr_recog (
  input  wire       clock_in,
  input  wire       resetn_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output wire [7:0] reg_rdata_out,
  input  wire       rx_done_in,
  input  wire [7:0] rx_byte_in,
  input  wire       rx_bit9_in,
  input  wire       rx_stop_ok_in,
  input  wire       tx_done_in,
  output wire       rx_accept_out,
  output wire [7:0] rx_data_out,
  output wire       rx_flag_out,
  output wire       tx_flag_out,
  output wire       framing_error_out,
  output wire [1:0] serial_mode_out,
  output wire       rx_enable_out,
  output wire       tx_bit9_out,
  output wire       variable_rate_out,
  output wire [6:0] fixed_divisor_out,
  output wire       address_match_out
);

  // register state
  reg  [7:0] slave_address_ff;
  reg  [7:0] slave_address_mask_ff;
  reg        serial_mode_bit0_ff;
  reg        serial_mode_bit1_ff;
  reg        multiprocessor_enable_ff;
  reg        rx_enable_ff;
  reg        tx_bit9_ff;
  reg        rx_bit9_ff;
  reg        transmit_flag_ff;
  reg        receive_interrupt_flag_ff;
  reg        framing_error_flag_ff;
  reg        framing_error_select_ff;
  reg        baud_double_ff;
  reg        double_speed_mode_ff;
  reg  [7:0] rdata_ff;
  reg  [7:0] rx_data_ff;
  reg        rx_accept_ff;
  reg  [6:0] fixed_divisor_ff;
  reg        variable_rate_ff;
  reg        match_ff;

  // next values
  reg  [7:0] nxt_slave_address;
  reg  [7:0] nxt_slave_address_mask;
  reg        nxt_serial_mode_bit0;
  reg        nxt_serial_mode_bit1;
  reg        nxt_multiprocessor_enable;
  reg        nxt_rx_enable;
  reg        nxt_tx_bit9;
  reg        nxt_rx_bit9;
  reg        nxt_transmit_flag;
  reg        nxt_receive_interrupt_flag;
  reg        nxt_framing_error_flag;
  reg        nxt_framing_error_select;
  reg        nxt_baud_double;
  reg        nxt_double_speed_mode;
  reg  [7:0] nxt_rdata;
  reg  [6:0] nxt_fixed_divisor;
  reg        nxt_variable_rate;

  // decode
  wire       sel_sc;
  wire       sel_sa;
  wire       sel_sm;
  wire       sel_pc;
  wire       sel_cc;
  wire [1:0] mode;
  wire [7:0] bcast_ref;
  wire [7:0] given_miss;
  wire [7:0] bcast_miss;
  wire       given_hit;
  wire       bcast_hit;
  wire       own_address;
  wire       mp_active;
  wire       fe_check;
  wire       stop_bad;
  wire       frame_in;
  reg        accept;
  reg  [7:0] sc_view;

  assign sel_sc = (reg_addr_in == `UAR_OFS_SERIAL_CONTROL);
  assign sel_sa = (reg_addr_in == `UAR_OFS_SLAVE_ADDRESS);
  assign sel_sm = (reg_addr_in == `UAR_OFS_SLAVE_ADDR_MASK);
  assign sel_pc = (reg_addr_in == `UAR_OFS_POWER_CONTROL);
  assign sel_cc = (reg_addr_in == `UAR_OFS_CLOCK_CONTROL);

  // two mode bits give shift, 8-bit uart, two 9-bit uarts
  assign mode = {serial_mode_bit0_ff, serial_mode_bit1_ff};

  // broadcast reference is address OR mask; its zeros never compare
  assign bcast_ref = slave_address_ff | slave_address_mask_ff;

  // per-bit mismatch: differing bit that the mask cares about
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cmp
      assign given_miss[gi] = (rx_byte_in[gi] ^ slave_address_ff[gi]) & slave_address_mask_ff[gi];
      assign bcast_miss[gi] = (rx_byte_in[gi] ^ bcast_ref[gi]) & bcast_ref[gi];
    end
  endgenerate

  // an all-ones mask leaves no don't-care bit, so only exact equality hits
  assign given_hit   = (given_miss == 8'h00);
  assign bcast_hit   = (bcast_miss == 8'h00);
  assign own_address = given_hit | bcast_hit;

  // multiprocessor feature is inert in shift mode whatever software wrote
  assign mp_active = multiprocessor_enable_ff & (mode != `UAR_MODE_SHIFT);
  assign fe_check  = framing_error_select_ff & (mode != `UAR_MODE_SHIFT);
  assign frame_in  = rx_done_in & rx_enable_ff;
  assign stop_bad  = frame_in & fe_check & ~rx_stop_ok_in;

  // frame acceptance; a pending receive flag blocks overwrite of the byte
  always @* begin
    accept = 1'b0;
    if (frame_in && !receive_interrupt_flag_ff) begin
      case (mode)
        `UAR_MODE_SHIFT: begin
          accept = 1'b1;
        end
        `UAR_MODE_UART8: begin
          if (mp_active) begin
            accept = own_address & rx_stop_ok_in;
          end else begin
            accept = 1'b1;
          end
        end
        `UAR_MODE_UART9_FIXED, `UAR_MODE_UART9_VAR: begin
          if (mp_active) begin
            accept = rx_bit9_in & own_address;
          end else begin
            accept = 1'b1;
          end
        end
        default: begin
          accept = 1'b0;
        end
      endcase
    end
  end

  // serial_control as software sees it; bit 7 is shared
  always @* begin
    sc_view    = 8'h00;
    sc_view[7] = framing_error_select_ff ? framing_error_flag_ff : serial_mode_bit0_ff;
    sc_view[6] = serial_mode_bit1_ff;
    sc_view[5] = multiprocessor_enable_ff;
    sc_view[4] = rx_enable_ff;
    sc_view[3] = tx_bit9_ff;
    sc_view[2] = rx_bit9_ff;
    sc_view[1] = transmit_flag_ff;
    sc_view[0] = receive_interrupt_flag_ff;
  end

  // register writes and hardware updates; hardware sets win over clears
  always @* begin
    nxt_slave_address          = slave_address_ff;
    nxt_slave_address_mask     = slave_address_mask_ff;
    nxt_serial_mode_bit0       = serial_mode_bit0_ff;
    nxt_serial_mode_bit1       = serial_mode_bit1_ff;
    nxt_multiprocessor_enable  = multiprocessor_enable_ff;
    nxt_rx_enable              = rx_enable_ff;
    nxt_tx_bit9                = tx_bit9_ff;
    nxt_rx_bit9                = rx_bit9_ff;
    nxt_transmit_flag          = transmit_flag_ff;
    nxt_receive_interrupt_flag = receive_interrupt_flag_ff;
    nxt_framing_error_flag     = framing_error_flag_ff;
    nxt_framing_error_select   = framing_error_select_ff;
    nxt_baud_double            = baud_double_ff;
    nxt_double_speed_mode      = double_speed_mode_ff;
    if (reg_wr_in) begin
      if (sel_sa) begin
        nxt_slave_address = reg_wdata_in;
      end
      if (sel_sm) begin
        nxt_slave_address_mask = reg_wdata_in;
      end
      if (sel_sc) begin
        if (framing_error_select_ff) begin
          nxt_framing_error_flag = reg_wdata_in[`UAR_SC_FE_OR_MODE0];
        end else begin
          nxt_serial_mode_bit0 = reg_wdata_in[`UAR_SC_FE_OR_MODE0];
        end
        nxt_serial_mode_bit1       = reg_wdata_in[`UAR_SC_MODE1];
        nxt_multiprocessor_enable  = reg_wdata_in[`UAR_SC_MP_ENABLE];
        nxt_rx_enable              = reg_wdata_in[`UAR_SC_RX_ENABLE];
        nxt_tx_bit9                = reg_wdata_in[`UAR_SC_TX_BIT9];
        nxt_rx_bit9                = reg_wdata_in[`UAR_SC_RX_BIT9];
        nxt_transmit_flag          = reg_wdata_in[`UAR_SC_TX_FLAG];
        nxt_receive_interrupt_flag = reg_wdata_in[`UAR_SC_RX_FLAG];
      end
      if (sel_pc) begin
        nxt_baud_double          = reg_wdata_in[`UAR_PC_BAUD_DOUBLE];
        nxt_framing_error_select = reg_wdata_in[`UAR_PC_FE_SELECT];
      end
      if (sel_cc) begin
        nxt_double_speed_mode = reg_wdata_in[`UAR_CC_DOUBLE_SPEED];
      end
    end
    // later good stop bits leave the flag alone; only software clears it
    if (stop_bad) begin
      nxt_framing_error_flag = 1'b1;
    end
    if (tx_done_in) begin
      nxt_transmit_flag = 1'b1;
    end
    if (accept) begin
      nxt_receive_interrupt_flag = 1'b1;
      if (mode != `UAR_MODE_SHIFT) begin
        nxt_rx_bit9 = rx_bit9_in;
      end
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_rd_in) begin
      if (sel_sc) begin
        nxt_rdata = sc_view;
      end else if (sel_sa) begin
        nxt_rdata = slave_address_ff;
      end else if (sel_sm) begin
        nxt_rdata = slave_address_mask_ff;
      end else if (sel_pc) begin
        nxt_rdata = {baud_double_ff, framing_error_select_ff, 6'h00};
      end else if (sel_cc) begin
        nxt_rdata = {7'h00, double_speed_mode_ff};
      end
    end
  end

  // fixed rate divisor for modes 0 and 2, zero marks a timer-driven rate;
  // built from next values so the rate never lags serial_mode_out by a cycle
  always @* begin
    nxt_fixed_divisor = `UAR_DIV_NONE;
    nxt_variable_rate = 1'b0;
    case ({nxt_serial_mode_bit0, nxt_serial_mode_bit1})
      `UAR_MODE_SHIFT: begin
        nxt_fixed_divisor = nxt_double_speed_mode ? `UAR_DIV_MODE0_X2 : `UAR_DIV_MODE0;
      end
      `UAR_MODE_UART9_FIXED: begin
        if (nxt_double_speed_mode) begin
          nxt_fixed_divisor = nxt_baud_double ? `UAR_DIV_MODE2_DBL_X2 : `UAR_DIV_MODE2_X2;
        end else begin
          nxt_fixed_divisor = nxt_baud_double ? `UAR_DIV_MODE2_DBL : `UAR_DIV_MODE2;
        end
      end
      `UAR_MODE_UART8, `UAR_MODE_UART9_VAR: begin
        nxt_variable_rate = 1'b1;
      end
      default: begin
        nxt_variable_rate = 1'b0;
      end
    endcase
  end

  // state update; address and mask clear on reset so every address hits
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      slave_address_ff          <= `UAR_RST_SLAVE_ADDRESS;
      slave_address_mask_ff     <= `UAR_RST_SLAVE_ADDR_MASK;
      serial_mode_bit0_ff       <= 1'b0;
      serial_mode_bit1_ff       <= 1'b0;
      multiprocessor_enable_ff  <= 1'b0;
      rx_enable_ff              <= 1'b0;
      tx_bit9_ff                <= 1'b0;
      rx_bit9_ff                <= 1'b0;
      transmit_flag_ff          <= 1'b0;
      receive_interrupt_flag_ff <= 1'b0;
      framing_error_flag_ff     <= 1'b0;
      framing_error_select_ff   <= 1'b0;
      baud_double_ff            <= 1'b0;
      double_speed_mode_ff      <= 1'b0;
      rdata_ff                  <= 8'h00;
      rx_data_ff                <= 8'h00;
      rx_accept_ff              <= 1'b0;
      fixed_divisor_ff          <= `UAR_DIV_MODE0;
      variable_rate_ff          <= 1'b0;
      match_ff                  <= 1'b0;
    end else begin
      slave_address_ff          <= nxt_slave_address;
      slave_address_mask_ff     <= nxt_slave_address_mask;
      serial_mode_bit0_ff       <= nxt_serial_mode_bit0;
      serial_mode_bit1_ff       <= nxt_serial_mode_bit1;
      multiprocessor_enable_ff  <= nxt_multiprocessor_enable;
      rx_enable_ff              <= nxt_rx_enable;
      tx_bit9_ff                <= nxt_tx_bit9;
      rx_bit9_ff                <= nxt_rx_bit9;
      transmit_flag_ff          <= nxt_transmit_flag;
      receive_interrupt_flag_ff <= nxt_receive_interrupt_flag;
      framing_error_flag_ff     <= nxt_framing_error_flag;
      framing_error_select_ff   <= nxt_framing_error_select;
      baud_double_ff            <= nxt_baud_double;
      double_speed_mode_ff      <= nxt_double_speed_mode;
      rdata_ff                  <= nxt_rdata;
      rx_accept_ff              <= accept;
      fixed_divisor_ff          <= nxt_fixed_divisor;
      variable_rate_ff          <= nxt_variable_rate;
      if (accept) begin
        rx_data_ff <= rx_byte_in;
      end
      if (frame_in) begin
        match_ff <= own_address;
      end
    end
  end

  // outputs, all from flip-flops
  assign reg_rdata_out     = rdata_ff;
  assign rx_accept_out     = rx_accept_ff;
  assign rx_data_out       = rx_data_ff;
  assign rx_flag_out       = receive_interrupt_flag_ff;
  assign tx_flag_out       = transmit_flag_ff;
  assign framing_error_out = framing_error_flag_ff;
  assign serial_mode_out   = mode;
  assign rx_enable_out     = rx_enable_ff;
  assign tx_bit9_out       = tx_bit9_ff;
  assign variable_rate_out = variable_rate_ff;
  assign fixed_divisor_out = fixed_divisor_ff;
  assign address_match_out = match_ff;

endmodule
`default_nettype wire

// ===== dv/uar_addr_recog_checker.sv
// port-level checks on flags, read data and rate outputs of uar_addr_recog
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module uar_addr_recog_checker (
  input wire logic       clock_in,
  input wire logic       resetn_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       rx_done_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic       rx_accept_out,
  input wire logic [7:0] rx_data_out,
  input wire logic       rx_flag_out,
  input wire logic       framing_error_out,
  input wire logic [1:0] serial_mode_out,
  input wire logic       rx_enable_out,
  input wire logic       variable_rate_out,
  input wire logic [6:0] fixed_divisor_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // mode 0 frame that nothing may block, then its acceptance
  sequence s_m0_frame; rx_done_in && rx_enable_out && !rx_flag_out && serial_mode_out == 2'h0; endsequence
  sequence s_taken; rx_accept_out && rx_flag_out; endsequence
  property p_m0_take; s_m0_frame |=> s_taken; endproperty
  a_m0_take: assert property (p_m0_take) else $error("mode 0 frame not taken");
  property p_acc_once; rx_accept_out |=> !rx_accept_out; endproperty
  a_acc_once: assert property (p_acc_once) else $error("accept twice in a row");
  property p_acc_cause; rx_accept_out |-> $past(rx_done_in) && rx_data_out == $past(rx_byte_in); endproperty
  a_acc_cause: assert property (p_acc_cause) else $error("accept without its frame");
  // flags only fall through a software write
  property p_flag_hold; rx_flag_out && !reg_wr_in |=> rx_flag_out; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("receive flag dropped");
  property p_fe_sticky; framing_error_out && !reg_wr_in |=> framing_error_out; endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("framing error dropped");
  property p_rd_idle; !$past(reg_rd_in) |-> reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_var_rate; variable_rate_out == serial_mode_out[0]; endproperty
  a_var_rate: assert property (p_var_rate) else $error("variable rate mode wrong");
  property p_fixed_zero; variable_rate_out |-> fixed_divisor_out == 7'h00; endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("divisor set in variable mode");
  property p_mode_hold; !reg_wr_in |=> $stable(serial_mode_out); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without write");
endmodule
bind uar_addr_recog uar_addr_recog_checker u_uar_addr_recog_checker (.clock_in(clock_in), .resetn_in(resetn_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_done_in(rx_done_in),
  .rx_byte_in(rx_byte_in), .rx_accept_out(rx_accept_out), .rx_data_out(rx_data_out), .rx_flag_out(rx_flag_out),
  .framing_error_out(framing_error_out), .serial_mode_out(serial_mode_out), .rx_enable_out(rx_enable_out),
  .variable_rate_out(variable_rate_out), .fixed_divisor_out(fixed_divisor_out));
`default_nettype wire

// ===== dv/uar_master_model.sv
// master node model: hands frames over at the receive shifter boundary
// assumes its tasks are called from the bench between clock edges
`timescale 1ns/100ps
`default_nettype none
module uar_master_model (
  input  wire logic       clock_in,
  output var  logic       rx_done_out,
  output var  logic [7:0] rx_byte_out,
  output var  logic       rx_bit9_out,
  output var  logic       rx_stop_ok_out,
  output var  logic       tx_done_out
);
  // idle lines at time zero
  initial begin
    rx_done_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_bit9_out = 1'b0;
    rx_stop_ok_out = 1'b0;
    tx_done_out = 1'b0;
  end
  // one frame; stale lines are inverted so they never look valid by luck
  task automatic send(input logic [7:0] b, input logic n, input logic s);
    @(posedge clock_in);
    rx_done_out <= 1'b1;
    rx_byte_out <= b; // all-ones byte reaches every slave
    rx_bit9_out <= n; // address frames carry ninth bit one
    rx_stop_ok_out <= s;
    @(posedge clock_in);
    rx_done_out <= 1'b0;
    rx_byte_out <= ~b;
    rx_bit9_out <= ~n;
    rx_stop_ok_out <= ~s;
  endtask
  // end of a transmitted frame
  task automatic txd;
    @(posedge clock_in);
    tx_done_out <= 1'b1;
    @(posedge clock_in);
    tx_done_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_uar_addr_recog.sv
// self-checking bench for uar_addr_recog through its register port
// assumes design, checker and master model compiled beforehand
`timescale 1ns/100ps
`default_nettype none
module tb_uar_addr_recog;
  logic       clock_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [7:0] sc = 8'h00;
  wire  [7:0] reg_rdata_out, rx_byte_in, rx_data_out;
  wire  [6:0] fixed_divisor_out;
  wire  [1:0] serial_mode_out;
  wire        rx_done_in, rx_bit9_in, rx_stop_ok_in, tx_done_in, rx_accept_out, rx_flag_out, tx_flag_out;
  wire        framing_error_out, rx_enable_out, tx_bit9_out, variable_rate_out, address_match_out;
  int         num_errors = 0;
  int         comparisons = 0;
  uar_addr_recog u_uar_addr_recog (.clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .rx_done_in(rx_done_in), .rx_byte_in(rx_byte_in), .rx_bit9_in(rx_bit9_in), .rx_stop_ok_in(rx_stop_ok_in),
    .tx_done_in(tx_done_in), .rx_accept_out(rx_accept_out), .rx_data_out(rx_data_out), .rx_flag_out(rx_flag_out),
    .tx_flag_out(tx_flag_out), .framing_error_out(framing_error_out), .serial_mode_out(serial_mode_out),
    .rx_enable_out(rx_enable_out), .tx_bit9_out(tx_bit9_out), .variable_rate_out(variable_rate_out),
    .fixed_divisor_out(fixed_divisor_out), .address_match_out(address_match_out));
  uar_master_model u_uar_master_model (.clock_in(clock_in), .rx_done_out(rx_done_in), .rx_byte_out(rx_byte_in),
    .rx_bit9_out(rx_bit9_in), .rx_stop_ok_out(rx_stop_ok_in), .tx_done_out(tx_done_in));
  // 4 ns period
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle strobes; the leading edge wait keeps a gap between calls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk("read data", e, reg_rdata_out);
  endtask
  // frame, verdict, then clear the receive flag for the next one
  task automatic fchk(input logic [7:0] b, input logic n, input logic s, input logic e);
    u_uar_master_model.send(b, n, s);
    #1 chk("accept", {7'h00, e}, {7'h00, rx_accept_out});
    if (e)
      chk("data", b, rx_data_out);
    wr(8'h98, sc);
  endtask
  task automatic t_reset;
    #1 chk("divisor", 8'h0C, {1'b0, fixed_divisor_out});
    rchk(8'hA9, 8'h00);
    rchk(8'hB9, 8'h00);
    rchk(8'h98, 8'h00);
    rchk(8'h00, 8'h00);
    sc = 8'hF0;
    wr(8'h98, sc);
    fchk(8'h3C, 1'b1, 1'b1, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_given;
    logic [31:0] tbl [10] = '{32'h56FC5501, 32'h56FC5200, 32'h56FCFE01, 32'hF1FAF001, 32'hF1FAF300,
                              32'hF1FAFB01, 32'hF2FDFB00, 32'hF2FDFF01, 32'h56FF5601, 32'h56FF5700};
    foreach (tbl[i]) begin
      wr(8'hA9, tbl[i][31:24]);
      wr(8'hB9, tbl[i][23:16]);
      fchk(tbl[i][15:8], 1'b1, 1'b1, tbl[i][0]);
      chk("match", {7'h00, tbl[i][0]}, {7'h00, address_match_out});
    end
    $display("address test done");
  endtask
  task automatic t_mp;
    fchk(8'h56, 1'b0, 1'b1, 1'b0);
    fchk(8'h56, 1'b1, 1'b1, 1'b1);
    sc = 8'hD0;
    wr(8'h98, sc);
    fchk(8'h57, 1'b0, 1'b1, 1'b1);
    sc = 8'h70;
    wr(8'h98, sc);
    fchk(8'h56, 1'b1, 1'b1, 1'b1);
    fchk(8'h56, 1'b1, 1'b0, 1'b0);
    fchk(8'h57, 1'b1, 1'b1, 1'b0);
    sc = 8'h30;
    wr(8'h98, sc);
    fchk(8'h57, 1'b0, 1'b1, 1'b1);
    $display("multiprocessor test done");
  endtask
  task automatic t_fe;
    sc = 8'h50;
    wr(8'h98, sc);
    wr(8'h87, 8'h40);
    u_uar_master_model.send(8'h56, 1'b0, 1'b0);
    #1 chk("fe set", 8'h01, {7'h00, framing_error_out});
    rchk(8'h98, 8'hD1);
    u_uar_master_model.send(8'h56, 1'b1, 1'b1);
    #1 chk("fe held", 8'h01, {7'h00, framing_error_out});
    wr(8'h98, sc);
    #1 chk("fe clear", 8'h00, {7'h00, framing_error_out});
    wr(8'h87, 8'h00);
    rchk(8'h98, sc);
    $display("framing test done");
  endtask
  task automatic t_modes;
    logic [6:0] dv [4] = '{7'h0C, 7'h00, 7'h40, 7'h00};
    for (int m = 0; m < 4; m++) begin
      wr(8'h98, {m[1:0], 6'h10});
      #1 chk("mode", m[7:0], {6'h00, serial_mode_out});
      chk("rate", {7'h00, m[0]}, {7'h00, variable_rate_out});
      chk("divisor", {1'b0, dv[m]}, {1'b0, fixed_divisor_out});
    end
    wr(8'h98, 8'h90);
    wr(8'h87, 8'h80);
    #1 chk("divisor", 8'h20, {1'b0, fixed_divisor_out});
    wr(8'h8F, 8'h01);
    #1 chk("divisor", 8'h10, {1'b0, fixed_divisor_out});
    wr(8'h98, 8'h18);
    #1 chk("divisor", 8'h06, {1'b0, fixed_divisor_out});
    chk("tx bit9", 8'h01, {7'h00, tx_bit9_out});
    u_uar_master_model.txd();
    #1 chk("tx flag", 8'h01, {7'h00, tx_flag_out});
    $display("mode test done");
  endtask
  task automatic print_verdict;
    $display("compared %0d, mismatched %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_reset();
    t_given();
    t_mp();
    t_fe();
    t_modes();
    print_verdict();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
